// [rtl/srpr_top.v]
`timescale 1ns/1ps
`include "srpr_map.vh"

// Summary of operation
// - Keep non-volatile and volatile copies; load volatile from non-volatile at power-up.
// - Pin-function bit acts only in single-lane mode, quad off, dedicated reset off.
// - Pin-function bit 0 gives pause input, 1 gives reset input when i_reset_pin_disable is high.
// - Parts with dedicated reset pin always give shared pin pause when quad off.
// - Quad enable or quad instruction mode makes shared pin the fourth data line.
// - Dummy field bits 6..3 sets 1 to 15 wait cycles; zero selects defaults.
// - Defaults: 8 fast/dual/quad output, 6 quad-mode fast and quad I/O, 4 dual I/O.
// - Wrap enable 0 wraps at array end; 1 wraps within burst length.
// - Burst field 00/01/10/11 gives 8/16/32/64 byte wrap.
// - Command 65h writes the non-volatile copy.
// - Commands C0h or 63h write only the volatile copy.
// - Configured dummy count applies to every accepted fast read variant, double rate included; quad instruction mode drops 3Bh, BBh, BDh and 6Bh.
module srpr_top (
    input  wire       i_ref_clk,
    input  wire       i_resetn,
    input  wire       i_clk_en,
    input  wire       i_sck,
    input  wire       i_cs_n,
    input  wire [3:0] i_io,
    input  wire       i_quad_enable_bit,
    input  wire       i_quad_instruction_mode,
    input  wire       i_reset_pin_disable,
    input  wire       i_has_dedicated_reset,
    input  wire       i_power_cycle,
    output wire       o_ready,
    output wire [7:0] o_read_param,
    output wire [7:0] o_nv_param,
    output wire       o_read_valid,
    output wire [7:0] o_read_opcode,
    output wire [3:0] o_dummy_cycles,
    output wire       o_double_rate,
    output wire       o_wrap_enable_bit,
    output wire [6:0] o_wrap_len,
    output wire [1:0] o_pin3_func
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam [5:0] SYNC_RST = 6'h02;

    wire [5:0] sync_in;
    wire [5:0] sync_out;
    wire       s_sck;
    wire       s_cs_n;
    wire [3:0] s_io;

    assign sync_in = {i_io, i_cs_n, i_sck};

    srpr_sync #(
        .WIDTH     (6)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_clk_en  (i_clk_en),
        .i_async   (sync_in),
        .i_rst_val (SYNC_RST),
        .o_sync    (sync_out)
    );

    assign s_sck  = sync_out[0];
    assign s_cs_n = sync_out[1];
    assign s_io   = sync_out[5:2];

    ////////////////////////////////////////////////////////////////////////////
    // State

    localparam [2:0] ST_LOAD = 3'h0;
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_OPC  = 3'h2;
    localparam [2:0] ST_DATA = 3'h3;
    localparam [2:0] ST_SKIP = 3'h4;

    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg        sck_prev_q;
    reg        cs_prev_q;
    reg  [7:0] shift_q;
    reg  [7:0] shift_d;
    reg  [3:0] cnt_q;
    reg  [3:0] cnt_d;
    reg  [1:0] wr_kind_q;
    reg  [1:0] wr_kind_d;
    reg  [7:0] wr_data_q;
    reg  [7:0] wr_data_d;
    reg        wr_full_q;
    reg        wr_full_d;
    reg  [7:0] nv_q;
    reg  [7:0] nv_d;
    reg  [7:0] vol_q;
    reg  [7:0] vol_d;
    reg        ready_q;
    reg        ready_d;
    reg        rd_valid_q;
    reg        rd_valid_d;
    reg  [7:0] rd_op_q;
    reg  [7:0] rd_op_d;
    reg  [3:0] dummy_q;
    reg  [3:0] dummy_d;
    reg        ddr_q;
    reg        ddr_d;
    reg        wrap_en_q;
    reg  [6:0] wrap_len_q;
    reg  [1:0] pin_func_q;
    reg  [1:0] pin_func_d;

    wire       quad_cmd;
    wire       sck_rise;
    wire       cs_rise;
    wire [3:0] step;
    wire [3:0] cnt_next;
    wire [7:0] shift_next;
    wire       byte_done;
    wire [3:0] dummy_field;
    wire [1:0] burst_field;

    // In quad instruction mode every phase moves four bits per clock
    assign quad_cmd    = i_quad_instruction_mode;
    assign sck_rise    = s_sck & ~sck_prev_q & ~s_cs_n;
    assign cs_rise     = s_cs_n & ~cs_prev_q;
    assign step        = quad_cmd ? `SRPR_STEP_QUAD : `SRPR_STEP_SINGLE;
    assign cnt_next    = cnt_q + step;
    assign shift_next  = quad_cmd ? {shift_q[3:0], s_io} : {shift_q[6:0], s_io[0]};
    assign byte_done   = sck_rise && (cnt_next == `SRPR_BYTE_BITS);
    assign dummy_field = vol_q[`SRPR_DUMMY_HI:`SRPR_DUMMY_LO];
    assign burst_field = vol_q[`SRPR_BURST_HI:`SRPR_BURST_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Read command decode and dummy count selection

    reg        is_read;
    reg        is_ddr;
    reg  [3:0] def_dummy;

    always @* begin
        is_read   = 1'b1;
        is_ddr    = 1'b0;
        def_dummy = `SRPR_DUMMY_DEF8;
        case (shift_next)
            `SRPR_OP_FAST: begin
                def_dummy = quad_cmd ? `SRPR_DUMMY_DEF6 : `SRPR_DUMMY_DEF8;
            end
            `SRPR_OP_FAST_DDR: begin
                is_ddr    = 1'b1;
                def_dummy = quad_cmd ? `SRPR_DUMMY_DEF6 : `SRPR_DUMMY_DEF8;
            end
            `SRPR_OP_DUAL_OUT: begin
                is_read   = ~quad_cmd;
                def_dummy = `SRPR_DUMMY_DEF8;
            end
            `SRPR_OP_DUAL_IO: begin
                is_read   = ~quad_cmd;
                def_dummy = `SRPR_DUMMY_DEF4;
            end
            `SRPR_OP_DUAL_DDR: begin
                // Host never sends this in quad instruction mode; dropped if it does
                is_read   = ~quad_cmd;
                is_ddr    = 1'b1;
                def_dummy = `SRPR_DUMMY_DEF4;
            end
            `SRPR_OP_QUAD_OUT: begin
                is_read   = ~quad_cmd;
                def_dummy = `SRPR_DUMMY_DEF8;
            end
            `SRPR_OP_QUAD_IO: begin
                def_dummy = `SRPR_DUMMY_DEF6;
            end
            `SRPR_OP_QUAD_DDR: begin
                is_ddr    = 1'b1;
                def_dummy = `SRPR_DUMMY_DEF6;
            end
            default: begin
                is_read   = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencer and register copies

    always @* begin
        state_d    = state_q;
        shift_d    = shift_q;
        cnt_d      = cnt_q;
        wr_kind_d  = wr_kind_q;
        wr_data_d  = wr_data_q;
        wr_full_d  = wr_full_q;
        nv_d       = nv_q;
        vol_d      = vol_q;
        ready_d    = ready_q;
        rd_valid_d = 1'b0;
        rd_op_d    = rd_op_q;
        dummy_d    = dummy_q;
        ddr_d      = ddr_q;
        if (sck_rise) begin
            shift_d = shift_next;
            cnt_d   = byte_done ? `SRPR_CNT_ZERO : cnt_next;
        end
        // Commit only on a complete frame, so a short frame leaves both copies intact
        if (cs_rise && wr_full_q) begin
            if (wr_kind_q == `SRPR_WR_NV) begin
                nv_d = wr_data_q;
            end else if (wr_kind_q == `SRPR_WR_VOL) begin
                vol_d = wr_data_q;
            end
        end
        case (state_q)
            ST_LOAD: begin
                vol_d   = nv_q;
                ready_d = 1'b1;
                state_d = ST_IDLE;
            end
            ST_IDLE: begin
                cnt_d     = `SRPR_CNT_ZERO;
                wr_kind_d = `SRPR_WR_NONE;
                wr_full_d = 1'b0;
                if (!s_cs_n) begin
                    state_d = ST_OPC;
                    if (sck_rise) begin
                        cnt_d = step;
                    end
                end
            end
            ST_OPC: begin
                if (byte_done) begin
                    if (shift_next == `SRPR_OP_SET_NV) begin
                        wr_kind_d = `SRPR_WR_NV;
                        state_d   = ST_DATA;
                    end else if (shift_next == `SRPR_OP_SET_V_A || shift_next == `SRPR_OP_SET_V_B) begin
                        wr_kind_d = `SRPR_WR_VOL;
                        state_d   = ST_DATA;
                    end else begin
                        state_d = ST_SKIP;
                        if (is_read) begin
                            // Field value wins unless zero
                            rd_valid_d = 1'b1;
                            rd_op_d    = shift_next;
                            ddr_d      = is_ddr;
                            dummy_d    = (dummy_field == `SRPR_DUMMY_ZERO) ? def_dummy : dummy_field;
                        end
                    end
                end
            end
            ST_DATA: begin
                if (byte_done) begin
                    wr_data_d = shift_next;
                    wr_full_d = 1'b1;
                    state_d   = ST_SKIP;
                end
            end
            ST_SKIP: begin
                state_d = ST_SKIP;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (s_cs_n && state_q != ST_LOAD) begin
            state_d = ST_IDLE;
        end
        // A power cycle restarts opcode capture in any open frame and reloads the working copy
        if (i_power_cycle) begin
            state_d = ST_LOAD;
            ready_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared pin function

    always @* begin
        if (i_quad_enable_bit || i_quad_instruction_mode) begin
            pin_func_d = `SRPR_PIN_DATA;
        end else if (i_has_dedicated_reset) begin
            pin_func_d = `SRPR_PIN_PAUSE;
        end else if (i_reset_pin_disable && vol_q[`SRPR_PIN_SEL_BIT]) begin
            pin_func_d = `SRPR_PIN_RESET;
        end else begin
            pin_func_d = `SRPR_PIN_PAUSE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flip-flops

    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q    <= ST_LOAD;
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
            shift_q    <= `SRPR_REG_DEFAULT;
            cnt_q      <= `SRPR_CNT_ZERO;
            wr_kind_q  <= `SRPR_WR_NONE;
            wr_data_q  <= `SRPR_REG_DEFAULT;
            wr_full_q  <= 1'b0;
            nv_q       <= `SRPR_NV_DEFAULT;
            vol_q      <= `SRPR_REG_DEFAULT;
            ready_q    <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_op_q    <= `SRPR_REG_DEFAULT;
            dummy_q    <= `SRPR_DUMMY_ZERO;
            ddr_q      <= 1'b0;
            wrap_en_q  <= 1'b0;
            wrap_len_q <= `SRPR_WRAP_NONE;
            pin_func_q <= `SRPR_PIN_PAUSE;
        end else if (i_clk_en) begin
            state_q    <= state_d;
            sck_prev_q <= s_sck;
            cs_prev_q  <= s_cs_n;
            shift_q    <= shift_d;
            cnt_q      <= cnt_d;
            wr_kind_q  <= wr_kind_d;
            wr_data_q  <= wr_data_d;
            wr_full_q  <= wr_full_d;
            nv_q       <= nv_d;
            vol_q      <= vol_d;
            ready_q    <= ready_d;
            rd_valid_q <= rd_valid_d;
            rd_op_q    <= rd_op_d;
            dummy_q    <= dummy_d;
            ddr_q      <= ddr_d;
            // Zero length means wrap at the array end
            wrap_en_q  <= vol_q[`SRPR_WRAP_EN_BIT];
            wrap_len_q <= vol_q[`SRPR_WRAP_EN_BIT] ? (`SRPR_WRAP_BASE << burst_field) : `SRPR_WRAP_NONE;
            pin_func_q <= pin_func_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_ready           = ready_q;
    assign o_read_param      = vol_q;
    assign o_nv_param        = nv_q;
    assign o_read_valid      = rd_valid_q;
    assign o_read_opcode     = rd_op_q;
    assign o_dummy_cycles    = dummy_q;
    assign o_double_rate     = ddr_q;
    assign o_wrap_enable_bit = wrap_en_q;
    assign o_wrap_len        = wrap_len_q;
    assign o_pin3_func       = pin_func_q;

endmodule // srpr_top

// [rtl/srpr_map.vh]
`ifndef SRPR_MAP_VH
`define SRPR_MAP_VH

// Read-parameter register layout
`define SRPR_PIN_SEL_BIT   7
`define SRPR_DUMMY_HI      6
`define SRPR_DUMMY_LO      3
`define SRPR_WRAP_EN_BIT   2
`define SRPR_BURST_HI      1
`define SRPR_BURST_LO      0
`define SRPR_REG_DEFAULT   8'h00
`define SRPR_NV_DEFAULT    8'h00

// Set-parameter commands
`define SRPR_OP_SET_NV     8'h65
`define SRPR_OP_SET_V_A    8'hc0
`define SRPR_OP_SET_V_B    8'h63

// Fast read commands
`define SRPR_OP_FAST       8'h0b
`define SRPR_OP_FAST_DDR   8'h0d
`define SRPR_OP_DUAL_OUT   8'h3b
`define SRPR_OP_DUAL_IO    8'hbb
`define SRPR_OP_DUAL_DDR   8'hbd
`define SRPR_OP_QUAD_OUT   8'h6b
`define SRPR_OP_QUAD_IO    8'heb
`define SRPR_OP_QUAD_DDR   8'hed

// Default dummy counts when the field is zero
`define SRPR_DUMMY_ZERO    4'h0
`define SRPR_DUMMY_DEF8    4'h8
`define SRPR_DUMMY_DEF6    4'h6
`define SRPR_DUMMY_DEF4    4'h4

// Burst wrap length base in bytes, shifted by the burst-size field
`define SRPR_WRAP_BASE     7'h08
`define SRPR_WRAP_NONE     7'h00

// Shared pin function codes
`define SRPR_PIN_PAUSE     2'h0
`define SRPR_PIN_RESET     2'h1
`define SRPR_PIN_DATA      2'h2

// Serial shifter
`define SRPR_BYTE_BITS     4'h8
`define SRPR_STEP_SINGLE   4'h1
`define SRPR_STEP_QUAD     4'h4
`define SRPR_CNT_ZERO      4'h0

// Pending write kinds
`define SRPR_WR_NONE       2'h0
`define SRPR_WR_VOL        2'h1
`define SRPR_WR_NV         2'h2

`endif

// [rtl/srpr_sync.v]
`timescale 1ns/1ps

// Two-stage synchroniser, one chain per bit
module srpr_sync #(
    parameter WIDTH = 6
) (
    input  wire             i_ref_clk,
    input  wire             i_resetn,
    input  wire             i_clk_en,
    input  wire [WIDTH-1:0] i_async,
    input  wire [WIDTH-1:0] i_rst_val,
    output wire [WIDTH-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            // Reset value is a tie-off constant at the instance
            always @(posedge i_ref_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else if (i_clk_en) begin
                    meta_q <= i_async[g] ^ i_rst_val[g];
                    sync_q <= meta_q;
                end
            end
            assign o_sync[g] = sync_q ^ i_rst_val[g];
        end
    endgenerate

endmodule // srpr_sync

// [dv/srpr_chk_assertions.sv]
`timescale 1ns/1ps
module srpr_chk (
    input wire       i_ref_clk,
    input wire       i_resetn,
    input wire       i_clk_en,
    input wire       i_sck,
    input wire       i_cs_n,
    input wire [3:0] i_io,
    input wire       i_quad_enable_bit,
    input wire       i_quad_instruction_mode,
    input wire       i_reset_pin_disable,
    input wire       i_has_dedicated_reset,
    input wire       i_power_cycle,
    input wire       o_ready,
    input wire [7:0] o_read_param,
    input wire [7:0] o_nv_param,
    input wire       o_read_valid,
    input wire [7:0] o_read_opcode,
    input wire [3:0] o_dummy_cycles,
    input wire       o_double_rate,
    input wire       o_wrap_enable_bit,
    input wire [6:0] o_wrap_len,
    input wire [1:0] o_pin3_func
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    wire quad_on = i_quad_enable_bit || i_quad_instruction_mode;
    ////////////////////////////////////////
    // Load drops ready for one cycle, then the working copy equals the stored copy
    sequence s_reload;
        ##[1:2] !o_ready ##1 (o_ready && o_read_param == o_nv_param);
    endsequence
    chk_reload_copy: assert property (i_power_cycle |-> s_reload)
        else $error("power-up load did not copy stored value");
    chk_ready_hold: assert property (!o_ready |=> o_ready)
        else $error("load took more than one cycle");
    chk_pin_quad: assert property (quad_on |=> o_pin3_func == 2'h2)
        else $error("shared pin not data line in quad");
    chk_pin_dedicated: assert property (!quad_on && i_has_dedicated_reset |=> o_pin3_func == 2'h0)
        else $error("shared pin not pause on dedicated-reset part");
    chk_pin_select: assert property (!quad_on && !i_has_dedicated_reset |=>
        o_pin3_func == {1'b0, $past(i_reset_pin_disable && o_read_param[7])})
        else $error("shared pin function wrong");
    chk_wrap_len: assert property (o_ready |=>
        o_wrap_len == ($past(o_read_param[2]) ? 7'h08 << $past(o_read_param[1:0]) : 7'h00))
        else $error("wrap length wrong");
    chk_wrap_en: assert property (o_ready |=> o_wrap_enable_bit == $past(o_read_param[2]))
        else $error("wrap enable wrong");
    chk_read_pulse: assert property (o_read_valid |=> !o_read_valid)
        else $error("read pulse longer than one cycle");
    chk_dummy_field: assert property (o_read_valid && o_read_param[6:3] != 4'h0 |->
        o_dummy_cycles == o_read_param[6:3])
        else $error("dummy count not taken from field");
    chk_ddr_flag: assert property (o_read_valid |->
        o_double_rate == (o_read_opcode inside {8'h0d, 8'hbd, 8'hed}))
        else $error("double rate flag wrong");
    chk_nv_quiet: assert property ((!i_cs_n) [*8] |-> $stable(o_nv_param))
        else $error("stored copy changed inside a frame");
    chk_nv_apart: assert property ($changed(o_nv_param) |-> $stable(o_read_param))
        else $error("stored write touched working copy");
    chk_freeze_hold: assert property (!i_clk_en |=>
        $stable(o_read_param) && $stable(o_nv_param) && $stable(o_pin3_func))
        else $error("state moved while clock enable low");
endmodule // srpr_chk

// [dv/srpr_host.sv]
`timescale 1ns/1ps
module srpr_host (
    output logic       o_sck,
    output logic       o_cs_n,
    output logic [3:0] o_io
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_io = 4'h0;
    end
    ////////////////////////////////////////
    // Clock far below every dummy-count limit, so any field value is safe
    task automatic frame(input logic [15:0] w, input int nb, input logic q, input int half);
        int i;
        o_cs_n = 1'b0;
        for (i = 0; i < nb; i += (q ? 4 : 1)) begin
            o_io = q ? w[15-i -: 4] : {{3{~w[15-i]}}, w[15-i]};
            #(half) o_sck = 1'b1;
            #(half) o_sck = 1'b0;
        end
        #(half) o_cs_n = 1'b1;
        // Released lines have no pull, so show the inverse rather than a stale value
        o_io = ~o_io;
        #(2 * half);
    endtask
endmodule // srpr_host

// [dv/test_serial_flash_read_param_register.sv]
`timescale 1ns/1ps
module test_serial_flash_read_param_register;
    logic       i_ref_clk = 1'b0;
    logic       i_resetn = 1'b0;
    logic       i_clk_en = 1'b1;
    logic       i_quad_enable_bit = 1'b0;
    logic       i_quad_instruction_mode = 1'b0;
    logic       i_reset_pin_disable = 1'b0;
    logic       i_has_dedicated_reset = 1'b0;
    logic       i_power_cycle = 1'b0;
    wire        i_sck;
    wire        i_cs_n;
    wire  [3:0] i_io;
    wire        o_ready;
    wire  [7:0] o_read_param;
    wire  [7:0] o_nv_param;
    wire        o_read_valid;
    wire  [7:0] o_read_opcode;
    wire  [3:0] o_dummy_cycles;
    wire        o_double_rate;
    wire        o_wrap_enable_bit;
    wire  [6:0] o_wrap_len;
    wire  [1:0] o_pin3_func;
    int         err_total = 0;
    int         check_count = 0;
    int         pulses = 0;
    int         n;
    logic [31:0] seed = 32'hadf9;
    logic [31:0] r;
    logic [7:0]  d;
    logic [7:0]  vol = 8'h00;
    logic [7:0]  ops [8] = '{8'h0b, 8'h0d, 8'h3b, 8'hbb, 8'hbd, 8'h6b, 8'heb, 8'hed};

    srpr_top dut (.*);
    srpr_host host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_io(i_io));

    always #2.5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) if (o_read_valid === 1'b1) pulses++;
    ////////////////////////////////////////
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] exp_dummy(input logic [7:0] op, input logic [3:0] f, input logic q);
        if (f != 4'h0) return {4'h0, f};
        case (op)
            8'h0b, 8'h0d: return q ? 8'h06 : 8'h08;
            8'hbb, 8'hbd: return 8'h04;
            8'heb, 8'hed: return 8'h06;
            default: return 8'h08;
        endcase
    endfunction

    function automatic logic [7:0] exp_pin(input logic sel);
        if (i_quad_enable_bit || i_quad_instruction_mode) return 8'h02;
        if (i_has_dedicated_reset) return 8'h00;
        return {7'h0, sel && i_reset_pin_disable};
    endfunction

    task cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task print_verdict();
        $display("err_total=%0d check_count=%0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task send(input logic [7:0] op, input logic [7:0] dat, input int nb);
        host.frame({op, dat}, nb, i_quad_instruction_mode, 32);
        repeat (8) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] op, input logic [3:0] f);
        int p;
        int k;
        logic hit;
        p = pulses;
        hit = !(i_quad_instruction_mode && (op == 8'h3b || op == 8'hbb || op == 8'h6b));
        host.frame({op, 8'h00}, 8, i_quad_instruction_mode, 32);
        for (k = 0; k < 20 && pulses == p && hit; k++) @(posedge i_ref_clk);
        #1;
        cmp(8'(pulses - p), {7'h0, hit});
        if (hit) begin
            cmp(o_read_opcode, op);
            cmp({4'h0, o_dummy_cycles}, exp_dummy(op, f, i_quad_instruction_mode));
            cmp({7'h0, o_double_rate}, {7'h0, (op == 8'h0d || op == 8'hbd || op == 8'hed)});
        end
    endtask
    ////////////////////////////////////////
    initial begin
        #400000;
        err_total++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge i_ref_clk);
        #1 i_resetn = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        #1;
        cmp(o_read_param, 8'h00);
        cmp(o_nv_param, 8'h00);
        cmp({7'h0, o_ready}, 8'h01);
        for (n = 0; n < 24; n++) begin
            r = rnd();
            @(posedge i_ref_clk);
            #1;
            {i_quad_enable_bit, i_has_dedicated_reset, i_reset_pin_disable} = r[2:0];
            i_quad_instruction_mode = (r[4:3] == 2'h3);
            d = r[15:8];
            // Corner cases first: every burst code with wrap on, then default and top dummy counts
            if (n < 4) d[2:0] = {1'b1, 2'(n)};
            if (n == 0 || n == 6) i_quad_instruction_mode = 1'b1;
            if (n < 8) d[6:3] = 4'h0;
            if (n == 8) d[6:3] = 4'hf;
            send(r[16] ? 8'hc0 : 8'h63, d, 16);
            vol = d;
            cmp(o_read_param, d);
            cmp(o_nv_param, 8'h00);
            cmp({1'b0, o_wrap_len}, d[2] ? (8'h08 << d[1:0]) : 8'h00);
            cmp({6'h0, o_pin3_func}, exp_pin(d[7]));
            if (!(i_quad_instruction_mode && ops[n % 8] == 8'hbd)) rd(ops[n % 8], d[6:3]);
        end
        r = rnd();
        d = r[7:0];
        send(8'h65, d, 16);
        cmp(o_nv_param, d);
        cmp(o_read_param, vol);
        send(8'hc0, ~d, 12);
        send(8'h5a, ~d, 16);
        cmp(o_read_param, vol);
        @(posedge i_ref_clk);
        #1 i_power_cycle = 1'b1;
        @(posedge i_ref_clk);
        #1 i_power_cycle = 1'b0;
        repeat (4) @(posedge i_ref_clk);
        #1;
        cmp(o_read_param, d);
        host.frame({8'hc0, 8'h2d}, 16, i_quad_instruction_mode, 32);
        repeat (8) @(posedge i_ref_clk);
        #1;
        cmp(o_read_param, 8'h2d);
        // Clock enable low: a whole frame must leave every copy untouched
        i_clk_en = 1'b0;
        send(8'hc0, 8'h77, 16);
        i_clk_en = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        #1;
        cmp(o_read_param, 8'h2d);
        cmp(o_nv_param, d);
        i_resetn = 1'b0;
        repeat (3) @(posedge i_ref_clk);
        #1 i_resetn = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        #1;
        cmp(o_nv_param, 8'h00);
        cmp(o_read_param, 8'h00);
        print_verdict();
    end
endmodule // test_serial_flash_read_param_register

bind srpr_top srpr_chk u_chk (.*);
